// [eftp_comparison.v]
/*
 * Permissive directional comparison logic for earth fault teleprotection,
 * with on/off control from three sources, send prolongation, transient
 * blocking, echo detection and an Avalon-MM register slave.
 * Assumes all fault and channel inputs are synchronous to clk_sys and that
 * the non-volatile store of the on/off state lives outside, fed back through
 * the nv_* ports.
 */
// Chosen here: the Avalon-MM register port and the register offsets.
// What this block does
// - Forward fault keys permissive send
// - Trip needs forward fault plus receive
// - Send prolongation only after own trip
// - Only forward-configured stage may key
// - Per-phase send/receive on two-terminal lines
// - Three-terminal: send both, AND receives
// - Line setting selects two or three ends
// - No single phase found: send all three
// - Phase segregation only with single-pole trip
// - Switch on/off from three sources
// - Switch on only from switching-off source
// - Active only when no source holds off
// - On/off state kept non-volatile
// - Channel disturbance blocks the scheme
// - Transient blocking suppresses false trips
// - Echo on receive without own fault
// - Shared channel uses same transmission mode
`timescale 1ns/1ps
`include "eftp_map.vh"

module eftp_comparison #(
  parameter PROLONG_W = 16,
  parameter LINK_TIMEOUT_CYC = (`EFTP_LINK_TIMEOUT_NS + `EFTP_CLK_NS - 1) / `EFTP_CLK_NS
) (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        fault_fwd,
  input  wire        fault_rev,
  input  wire [2:0]  phase_sel,
  input  wire        own_trip,
  input  wire [2:0]  recv_end1,
  input  wire [2:0]  recv_end2,
  input  wire        chan_disturb,
  input  wire        link_alive,
  input  wire        sys_off_cmd,
  input  wire        sys_on_cmd,
  input  wire        bin_off_cmd,
  input  wire        bin_on_cmd,
  input  wire [2:0]  nv_src_off,
  input  wire        nv_valid,
  output reg  [2:0]  nv_src_off_out,
  output reg  [2:0]  send_end1,
  output reg  [2:0]  send_end2,
  output reg         teleprot_trip,
  output reg  [2:0]  teleprot_trip_ph,
  output reg         echo_active,
  output reg         teleprot_active,
  output reg         irq
);

  reg [31:0]          ctrl;
  reg [PROLONG_W-1:0] prolong_cyc;
  reg [PROLONG_W-1:0] trans_blk_cyc;
  reg [3:0]           irq_stat;
  reg [3:0]           irq_en;
  reg [2:0]           src_off;
  reg                 nv_loaded;
  reg [PROLONG_W-1:0] prolong_cnt;
  reg [PROLONG_W-1:0] trans_cnt;
  reg [15:0]          link_cnt;
  reg                 send_q;
  reg                 trip_q;
  reg                 rev_q;

  // Reset values cut to the timer width on purpose
  localparam [31:0] PROLONG_RST = `EFTP_PROLONG_RESET;
  localparam [31:0] TRANS_RST   = `EFTP_TRANS_BLK_RESET;

  wire bus_hit  = (avs_read | avs_write) & avs_waitrequest;
  wire wr_ctrl  = avs_write & bus_hit & (avs_address == `EFTP_OFS_CTRL);
  wire wr_clr   = avs_write & bus_hit & (avs_address == `EFTP_OFS_IRQ_CLR);
  wire ctrl_on  = ctrl[`EFTP_CTRL_SW_ON];
  wire three_t  = ctrl[`EFTP_CTRL_THREE_TERM];
  wire fwd_ok   = ctrl[`EFTP_CTRL_FWD_STAGE];

  wire seg_en = ctrl[`EFTP_CTRL_PHASE_SEG] & ctrl[`EFTP_CTRL_SP_TRIP] & ~three_t;

  // Any source off keeps block inactive
  wire active = (src_off == 3'b000);

  // Binary input or own link watchdog
  wire link_fail = ctrl[`EFTP_CTRL_DIGITAL] & (link_cnt >= LINK_TIMEOUT_CYC[15:0]);
  wire chan_bad  = ctrl[`EFTP_CTRL_DIGITAL] ? link_fail : chan_disturb;

  // Blocked for a while after reverse fault
  wire trans_blk = (trans_cnt != {PROLONG_W{1'b0}});

  wire fwd = fault_fwd & fwd_ok;

  wire [2:0] ph_key = (phase_sel == 3'b000) ? 3'b111 : phase_sel;

  // Prolongation runs only after own trip
  wire send_core = active & ~chan_bad & ~trans_blk & (fwd | (prolong_cnt != {PROLONG_W{1'b0}}));

  wire [2:0] next_send = send_core ? (seg_en ? ph_key : 3'b111) : 3'b000;

  // AND of both ends on teed lines
  wire [2:0] rx_comb = three_t ? (recv_end1 & recv_end2) : recv_end1;
  wire [2:0] rx_eff  = seg_en ? rx_comb : {3{|rx_comb}};

  // Own forward fault plus permissive receive
  wire [2:0] next_trip_ph = (active & ~chan_bad & ~trans_blk & fwd) ? (rx_eff & ph_key) : 3'b000;
  wire       next_trip    = |next_trip_ph;

  // Any end received, no own fault
  wire rx_any     = three_t ? (|recv_end1 | |recv_end2) : |recv_end1;
  wire next_echo  = active & ~chan_bad & rx_any & ~fault_fwd & ~fault_rev;

  wire [3:0] ev = {link_fail, next_echo & ~echo_active,
                   next_trip & ~trip_q, send_core & ~send_q};

  // On/off sources
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      src_off   <= 3'b000;
      nv_loaded <= 1'b0;
      ctrl      <= `EFTP_CTRL_RESET;
    end else begin
      if (!nv_loaded && nv_valid) begin
        src_off   <= nv_src_off;
        nv_loaded <= 1'b1;
        ctrl[`EFTP_CTRL_SW_ON] <= ~nv_src_off[`EFTP_SRC_PARAM];
      end else begin
        if (wr_ctrl && avs_byteenable[0]) begin
          ctrl[7:0] <= avs_writedata[7:0];
          if (!avs_writedata[`EFTP_CTRL_SW_ON])
            src_off[`EFTP_SRC_PARAM] <= 1'b1;
          else if (src_off[`EFTP_SRC_PARAM])
            src_off[`EFTP_SRC_PARAM] <= 1'b0;
        end
        if (sys_off_cmd)
          src_off[`EFTP_SRC_SYS] <= 1'b1;
        else if (sys_on_cmd && src_off[`EFTP_SRC_SYS])
          src_off[`EFTP_SRC_SYS] <= 1'b0;
        if (bin_off_cmd)
          src_off[`EFTP_SRC_BIN] <= 1'b1;
        else if (bin_on_cmd && src_off[`EFTP_SRC_BIN])
          src_off[`EFTP_SRC_BIN] <= 1'b0;
      end
    end
  end

  // Timers and scheme outputs
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prolong_cnt      <= {PROLONG_W{1'b0}};
      trans_cnt        <= {PROLONG_W{1'b0}};
      link_cnt         <= 16'h0000;
      send_q           <= 1'b0;
      trip_q           <= 1'b0;
      rev_q            <= 1'b0;
      send_end1        <= 3'b000;
      send_end2        <= 3'b000;
      teleprot_trip    <= 1'b0;
      teleprot_trip_ph <= 3'b000;
      echo_active      <= 1'b0;
      teleprot_active  <= 1'b0;
      nv_src_off_out   <= 3'b000;
    end else begin
      // Reload on forward fault with own trip
      if (fwd && own_trip)
        prolong_cnt <= prolong_cyc;
      else if (!fwd && prolong_cnt != {PROLONG_W{1'b0}})
        prolong_cnt <= prolong_cnt - {{(PROLONG_W-1){1'b0}}, 1'b1};
      else if (!fwd)
        prolong_cnt <= {PROLONG_W{1'b0}};
      rev_q <= fault_rev;
      if (fault_rev)
        trans_cnt <= trans_blk_cyc;
      else if (trans_cnt != {PROLONG_W{1'b0}} && !(rev_q && fault_fwd))
        trans_cnt <= trans_cnt - {{(PROLONG_W-1){1'b0}}, 1'b1};
      if (link_alive)
        link_cnt <= 16'h0000;
      else if (link_cnt < LINK_TIMEOUT_CYC[15:0])
        link_cnt <= link_cnt + 16'h0001;
      send_q           <= send_core;
      trip_q           <= next_trip;
      // Same send to both remote ends on three-terminal lines, end 2 idle otherwise
      send_end1        <= next_send;
      send_end2        <= three_t ? next_send : 3'b000;
      teleprot_trip    <= next_trip;
      teleprot_trip_ph <= next_trip_ph;
      echo_active      <= next_echo;
      teleprot_active  <= active;
      nv_src_off_out   <= src_off;
    end
  end

  // Register slave, one wait cycle per access
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      prolong_cyc     <= PROLONG_RST[PROLONG_W-1:0];
      trans_blk_cyc   <= TRANS_RST[PROLONG_W-1:0];
      irq_en          <= 4'h0;
      irq_stat        <= 4'h0;
      irq             <= 1'b0;
    end else begin
      avs_waitrequest <= ~bus_hit;
      if (avs_write && bus_hit) begin
        case (avs_address)
          `EFTP_OFS_PROLONG:   prolong_cyc   <= avs_writedata[PROLONG_W-1:0];
          `EFTP_OFS_TRANS_BLK: trans_blk_cyc <= avs_writedata[PROLONG_W-1:0];
          `EFTP_OFS_IRQ_EN:    irq_en        <= avs_writedata[3:0];
          default:             irq_en        <= irq_en;
        endcase
      end
      // Set wins over a simultaneous clear
      irq_stat <= ev | (irq_stat & ~(wr_clr ? avs_writedata[3:0] : 4'h0));
      irq      <= |((ev | (irq_stat & ~(wr_clr ? avs_writedata[3:0] : 4'h0))) & irq_en);
      if (avs_read && bus_hit) begin
        case (avs_address)
          `EFTP_OFS_CTRL:      avs_readdata <= {26'h0, ctrl[5:1], ~src_off[`EFTP_SRC_PARAM]};
          `EFTP_OFS_PROLONG:   avs_readdata <= {{(32-PROLONG_W){1'b0}}, prolong_cyc};
          `EFTP_OFS_TRANS_BLK: avs_readdata <= {{(32-PROLONG_W){1'b0}}, trans_blk_cyc};
          `EFTP_OFS_STATUS:    avs_readdata <= {24'h0, chan_bad, trans_blk, active, echo_active,
                                                teleprot_trip, send_q, seg_en, three_t};
          `EFTP_OFS_IRQ_STAT:  avs_readdata <= {28'h0, irq_stat};
          `EFTP_OFS_IRQ_EN:    avs_readdata <= {28'h0, irq_en};
          `EFTP_OFS_SRC_OFF:   avs_readdata <= {29'h0, src_off};
          // Arbitrary identification value
          `EFTP_OFS_ID:        avs_readdata <= `EFTP_ID_VALUE;
          default:             avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // One channel per direction, mode shared by caller

endmodule // eftp_comparison

// [eftp_comparison_sva.sv]
/* Port checker for the comparison block.
   Assumes it is bound onto eftp_comparison at clk_sys. */
`timescale 1ns/1ps
module eftp_comparison_sva (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       fault_fwd,
  input wire logic [2:0] recv_end1,
  input wire logic [2:0] recv_end2,
  input wire logic [2:0] send_end1,
  input wire logic [2:0] send_end2,
  input wire logic       teleprot_trip,
  input wire logic       teleprot_active,
  input wire logic       echo_active,
  input wire logic [2:0] nv_src_off_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_trip_cause: assert property (teleprot_trip |-> $past(fault_fwd) && $past(|recv_end1))
    else $error("trip without forward fault and receive");
  a_send_cause: assert property (|send_end1 |-> $past(fault_fwd) || $past(|send_end1))
    else $error("send without forward fault");
  a_send_both: assert property (|send_end2 |-> send_end2 == send_end1)
    else $error("second end send differs");
  a_echo_cause: assert property (echo_active |-> !$past(fault_fwd) && $past(|(recv_end1 | recv_end2)))
    else $error("echo without receive or with own fault");
  a_off_quiet: assert property (!teleprot_active && !$past(teleprot_active) |-> !teleprot_trip && send_end1 == 3'h0)
    else $error("output while switched off");
  a_off_source: assert property (nv_src_off_out != 3'h0 && $past(nv_src_off_out) != 3'h0 |-> !teleprot_active)
    else $error("active while a source holds off");
  a_trip_active: assert property (teleprot_trip |-> teleprot_active || $past(teleprot_active))
    else $error("trip while inactive");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
endmodule // eftp_comparison_sva
bind eftp_comparison eftp_comparison_sva i_eftp_comparison_sva (.clk_sys, .rst_b, .avs_read, .avs_write,
  .avs_waitrequest, .fault_fwd, .recv_end1, .recv_end2, .send_end1, .send_end2, .teleprot_trip,
  .teleprot_active, .echo_active, .nv_src_off_out);

// [eftp_comparison_test.sv]
/* Self-checking bench for the comparison block.
   Assumes the register map header and the remote end model. */
`timescale 1ns/1ps
`include "eftp_map.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module eftp_comparison_test;
  reg         clk_sys, rst_b, avs_read, avs_write, fault_fwd, own_trip, nv_valid, remote_fwd, chan_fail;
  reg         sys_off_cmd, sys_on_cmd, bin_off_cmd, bin_on_cmd, fault_rev;
  reg  [7:0]  avs_address;
  reg  [31:0] avs_writedata, q;
  reg  [2:0]  phase_sel, recv_end2;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, chan_disturb, teleprot_trip, echo_active, teleprot_active, irq;
  wire [2:0]  recv_end1, send_end1, send_end2, trip_ph, nv_out;
  integer     err_count, samples_checked;
  eftp_comparison i_eftp_comparison (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fault_fwd(fault_fwd), .fault_rev(fault_rev),
    .phase_sel(phase_sel), .own_trip(own_trip), .recv_end1(recv_end1), .recv_end2(recv_end2),
    .chan_disturb(chan_disturb), .link_alive(1'b0), .sys_off_cmd(sys_off_cmd), .sys_on_cmd(sys_on_cmd),
    .bin_off_cmd(bin_off_cmd), .bin_on_cmd(bin_on_cmd), .nv_src_off(3'h0), .nv_valid(nv_valid),
    .nv_src_off_out(nv_out), .send_end1(send_end1), .send_end2(send_end2), .teleprot_trip(teleprot_trip),
    .teleprot_trip_ph(trip_ph), .echo_active(echo_active), .teleprot_active(teleprot_active), .irq(irq));
  eftp_remote_end i_eftp_remote_end (.clk_sys(clk_sys), .rst_b(rst_b), .remote_fwd(remote_fwd),
    .chan_fail(chan_fail), .recv_out(recv_end1), .disturb_out(chan_disturb));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task end_of_test;
    begin
      if (err_count == 0 && samples_checked > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  task step(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Request held until waitrequest is seen low
  task bus(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_sys);
      avs_address <= a; avs_writedata <= d; avs_write <= w; avs_read <= !w;
      n = 0;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      if (n >= 20) begin
        err_count++;
        end_of_test;
      end
      q = avs_readdata;
      avs_write <= 1'b0; avs_read <= 1'b0;
    end
  endtask
  task pulse(input [3:0] m);
    begin
      {sys_off_cmd, sys_on_cmd, bin_off_cmd, bin_on_cmd} <= m;
      step(1);
      {sys_off_cmd, sys_on_cmd, bin_off_cmd, bin_on_cmd} <= 4'h0;
      step(3);
    end
  endtask
  task fault(input f, input r, input t);
    begin
      fault_fwd <= f; remote_fwd <= r; own_trip <= t;
      step(5);
    end
  endtask
  task t_regs;
    begin
      bus(0, `EFTP_OFS_CTRL, 0); `CHK(q, `EFTP_CTRL_RESET)
      bus(0, `EFTP_OFS_PROLONG, 0); `CHK(q, `EFTP_PROLONG_RESET)
      bus(0, 8'h40, 0); `CHK(q, 32'h00000000)
      bus(1, `EFTP_OFS_TRANS_BLK, 32'h00000003);
    end
  endtask
  task t_trip;
    begin
      bus(1, `EFTP_OFS_CTRL, 32'h00000001);
      fault(1, 1, 0); `CHK(send_end1, 3'h0)
      bus(1, `EFTP_OFS_CTRL, 32'h00000011);
      fault(1, 1, 0); `CHK(send_end1, 3'h7)
      `CHK(teleprot_trip, 1'b1)
      `CHK(send_end2, 3'h0)
      fault(1, 0, 0); `CHK(teleprot_trip, 1'b0)
      fault(0, 1, 0); `CHK(echo_active, 1'b1)
      `CHK(send_end1, 3'h0)
      fault(0, 0, 0);
      bus(1, `EFTP_OFS_CTRL, 32'h0000001D);
      phase_sel <= 3'h1;
      fault(1, 1, 0); `CHK(send_end1, 3'h1)
      `CHK(trip_ph, 3'h1)
      phase_sel <= 3'h0;
      fault(1, 1, 0); `CHK(send_end1, 3'h7)
      bus(1, `EFTP_OFS_CTRL, 32'h00000015);
      phase_sel <= 3'h1;
      fault(1, 1, 0); `CHK(send_end1, 3'h7)
      phase_sel <= 3'h0;
      fault(0, 0, 0);
      bus(1, `EFTP_OFS_CTRL, 32'h00000011);
    end
  endtask
  task t_prolong;
    begin
      bus(1, `EFTP_OFS_PROLONG, 32'h00000008);
      fault(1, 0, 0); fault(0, 0, 0); `CHK(send_end1, 3'h0)
      fault(1, 0, 1); fault(0, 0, 0); `CHK(send_end1, 3'h7)
      step(10); `CHK(send_end1, 3'h0)
    end
  endtask
  task t_three;
    begin
      bus(1, `EFTP_OFS_CTRL, 32'h00000013);
      fault(1, 1, 0); `CHK(send_end2, 3'h7)
      `CHK(teleprot_trip, 1'b0)
      recv_end2 <= 3'h7;
      fault(1, 1, 0); `CHK(teleprot_trip, 1'b1)
      recv_end2 <= 3'h0;
      fault(0, 0, 0);
      bus(1, `EFTP_OFS_CTRL, 32'h00000011);
    end
  endtask
  task t_irq;
    begin
      bus(1, `EFTP_OFS_IRQ_EN, 32'h00000002);
      fault(1, 1, 0); `CHK(irq, 1'b1)
      fault(0, 0, 0);
      bus(0, `EFTP_OFS_IRQ_STAT, 0); `CHK(q[`EFTP_IRQ_TRIP], 1'b1)
      bus(1, `EFTP_OFS_IRQ_CLR, 32'h0000000F); step(2); `CHK(irq, 1'b0)
      chan_fail <= 1'b1;
      fault(1, 1, 0); `CHK(teleprot_trip, 1'b0)
      chan_fail <= 1'b0;
      fault(0, 0, 0);
      fault_rev <= 1'b1;
      step(1);
      fault_rev <= 1'b0;
      fault(1, 1, 0); `CHK(teleprot_trip, 1'b0)
      step(3); `CHK(teleprot_trip, 1'b1)
      fault(0, 0, 0);
    end
  endtask
  task t_onoff;
    begin
      pulse(4'h8); `CHK(teleprot_active, 1'b0)
      `CHK(nv_out, 3'h2)
      bus(1, `EFTP_OFS_CTRL, 32'h00000011); step(3); `CHK(teleprot_active, 1'b0)
      pulse(4'h2); pulse(4'h4); `CHK(teleprot_active, 1'b0)
      bus(0, `EFTP_OFS_SRC_OFF, 0); `CHK(q, 32'h00000004)
      pulse(4'h1); `CHK(teleprot_active, 1'b1)
    end
  endtask
  initial begin
    err_count = 0; samples_checked = 0; rst_b = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
    avs_address = 8'h00; avs_writedata = 32'h0; fault_fwd = 1'b0; own_trip = 1'b0; nv_valid = 1'b0;
    remote_fwd = 1'b0; chan_fail = 1'b0; phase_sel = 3'h0; recv_end2 = 3'h0; fault_rev = 1'b0;
    {sys_off_cmd, sys_on_cmd, bin_off_cmd, bin_on_cmd} = 4'h0;
    step(10);
    rst_b <= 1'b1;
    nv_valid <= 1'b1;
    step(1);
    nv_valid <= 1'b0;
    t_regs; t_trip; t_prolong; t_three; t_irq; t_onoff;
    end_of_test;
  end
endmodule // eftp_comparison_test

// [eftp_map.vh]
/*
 * Register map, field positions, reset values and timing counts for the
 * earth fault teleprotection comparison block.
 * Assumes a 32-bit Avalon-MM slave port with word addressing by byte offset.
 */
`ifndef EFTP_MAP_VH
`define EFTP_MAP_VH

`define EFTP_OFS_CTRL        8'h00
`define EFTP_OFS_PROLONG     8'h04
`define EFTP_OFS_TRANS_BLK   8'h08
`define EFTP_OFS_STATUS      8'h0C
`define EFTP_OFS_IRQ_STAT    8'h10
`define EFTP_OFS_IRQ_CLR     8'h14
`define EFTP_OFS_IRQ_EN      8'h18
`define EFTP_OFS_SRC_OFF     8'h1C
`define EFTP_OFS_ID          8'h20

`define EFTP_CTRL_SW_ON      0
`define EFTP_CTRL_THREE_TERM 1
`define EFTP_CTRL_PHASE_SEG  2
`define EFTP_CTRL_SP_TRIP    3
`define EFTP_CTRL_FWD_STAGE  4
`define EFTP_CTRL_DIGITAL    5
`define EFTP_CTRL_RESET      32'h00000001

`define EFTP_IRQ_SEND        0
`define EFTP_IRQ_TRIP        1
`define EFTP_IRQ_ECHO        2
`define EFTP_IRQ_CHAN_FAIL   3
`define EFTP_IRQ_BITS        4

`define EFTP_SRC_PARAM       0
`define EFTP_SRC_SYS         1
`define EFTP_SRC_BIN         2

`define EFTP_PROLONG_RESET   32'h00000064
`define EFTP_TRANS_BLK_RESET 32'h00000064
`define EFTP_ID_VALUE        32'h0000E0F1
`define EFTP_LINK_TIMEOUT_NS 1000
`define EFTP_CLK_NS          10

`endif

// [eftp_remote_end.sv]
/* Opposite line end: permissive send and conventional channel alarm.
   Assumes the bench sets its fault view between clock edges. */
`timescale 1ns/1ps
module eftp_remote_end (
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire       remote_fwd,
  input  wire       chan_fail,
  output reg  [2:0] recv_out,
  output reg        disturb_out
);
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      recv_out    <= 3'h0;
      disturb_out <= 1'b0;
    end else begin
      recv_out    <= chan_fail ? ~recv_out : (remote_fwd ? 3'h7 : 3'h0);
      disturb_out <= chan_fail;
    end
  end
endmodule // eftp_remote_end
